// ===== src/scaler_codec_pkg.sv
// Package: register map, field layout, reset values and decode enums
package scaler_codec_pkg;
   // ---------------------------------------------------------------
   // Register byte addresses (printed offsets not all multiples of four)
   // ---------------------------------------------------------------
   localparam logic [11:0] ENCODE_SCALER_RATES_IDX = 12'h96C;
   localparam logic [11:0] ENCODE_SCALER_MODE_IDX = 12'h96E;
   localparam logic [11:0] CODEC_MODULE_CONTROL_IDX = 12'h980;
   localparam logic [11:0] ENCODE_SCALER_CONTROL_IDX = 12'h960;
   localparam logic [11:0] CAMERA_INPUT_FORMAT_IDX = 12'h110;
   localparam logic [13:0] ENCODE_SCALER_RATES_ADDR = {ENCODE_SCALER_RATES_IDX, 2'b00};
   localparam logic [13:0] ENCODE_SCALER_MODE_ADDR = {ENCODE_SCALER_MODE_IDX, 2'b00};
   localparam logic [13:0] CODEC_MODULE_CONTROL_ADDR = {CODEC_MODULE_CONTROL_IDX, 2'b00};
   localparam logic [13:0] ENCODE_SCALER_CONTROL_ADDR = {ENCODE_SCALER_CONTROL_IDX, 2'b00};
   localparam logic [13:0] CAMERA_INPUT_FORMAT_ADDR = {CAMERA_INPUT_FORMAT_IDX, 2'b00};

   // ---------------------------------------------------------------
   // Reset values
   // ---------------------------------------------------------------
   localparam logic [15:0] RATES_RESET = 16'h0101;
   localparam logic [15:0] MODE_RESET = 16'h0000;
   localparam logic [15:0] CONTROL_RESET = 16'h0000;
   localparam logic [15:0] SCALER_CTRL_RESET = 16'h0000;
   localparam logic [15:0] CAMERA_FMT_RESET = 16'h0000;

   // ---------------------------------------------------------------
   // Field positions
   // ---------------------------------------------------------------
   localparam int HRATE_LSB = 0;
   localparam int VRATE_LSB = 8;
   localparam int MODE_LSB = 0;
   localparam int ROTATE_BIT = 8;
   localparam int SOFT_RESET_BIT = 7;
   localparam int NO_OFFSET_BIT = 4;
   localparam int PATH_LSB = 1;
   localparam int ENABLE_BIT = 0;
   localparam int INDEP_BIT = 2;
   localparam int SCALER_EN_BIT = 0;
   localparam int CAM_STRAIGHT_BIT = 8;
   localparam int CAM_OFFSET_IN_BIT = 9;
   localparam logic [15:0] RATES_MASK = 16'h3F3F;
   localparam logic [15:0] MODE_MASK = 16'h0003;
   localparam logic [15:0] CONTROL_MASK = 16'h011F;
   localparam logic [15:0] SCALER_CTRL_MASK = 16'h0005;
   localparam logic [15:0] CAMERA_FMT_MASK = 16'h0300;
   localparam logic [5:0] RATE_MIN = 6'h01;
   localparam logic [5:0] RATE_MAX = 6'h20;

   // ---------------------------------------------------------------
   // Enumerations
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {
      SCALE_NONE = 2'h0,
      SCALE_REDUCE = 2'h1,
      SCALE_REDUCE_AVG = 2'h2,
      SCALE_RESERVED = 2'h3
   } scale_mode_t;

   typedef enum logic [2:0] {
      PATH_CODEC = 3'h0,
      PATH_YUV422_IN = 3'h1,
      PATH_RSVD2 = 3'h2,
      PATH_YUV422_OUT = 3'h3,
      PATH_HOST_CODEC = 3'h4,
      PATH_YUV420_IN = 3'h5,
      PATH_RSVD6 = 3'h6,
      PATH_YUV420_OUT = 3'h7
   } data_path_t;
endpackage

// ===== src/cfg_bus_if.sv
// Interface: decoded register-file read and write strobes shared with the APB front end
`timescale 1ns/1ps
interface cfg_bus_if;
   logic wr_en;
   logic rd_en;
   logic [13:0] addr;
   logic [15:0] wdata;
   logic [15:0] rdata;
   logic hit;
   modport front (output wr_en, output rd_en, output addr, output wdata,
      input rdata, input hit);
   modport regs (input wr_en, input rd_en, input addr, input wdata,
      output rdata, output hit);
endinterface

// ===== src/apb_front.sv
// APB slave front end: zero-wait access, error on unmapped address
`timescale 1ns/1ps
module apb_front
   import scaler_codec_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   cfg_bus_if.front bus
);
   logic [31:0] prdata_reg;
   logic [31:0] prdata_next;
   logic access;

   // --------------------------------------------------------------
   // Access phase decode
   // --------------------------------------------------------------
   // Zero-wait slave: every access ends in its first access cycle
   assign access = psel & penable;
   assign pready = access;
   assign pslverr = access & ~bus.hit;
   assign bus.wr_en = access & pwrite & bus.hit;
   assign bus.rd_en = psel & ~penable & ~pwrite;
   assign bus.addr = paddr[13:0];
   assign bus.wdata = pwdata[15:0];
   assign prdata = prdata_reg;

   // Read data is registered at the end of setup, so it stands through access
   always_comb begin
      prdata_next = prdata_reg;
      if (bus.rd_en) begin
         prdata_next = {16'h0000, bus.rdata};
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_reg <= 32'h0000_0000;
      end else begin
         prdata_reg <= prdata_next;
      end
   end
endmodule

// ===== src/capture_scaler_and_jpeg_control.sv
// Top: encode-side scaler rate/mode registers and codec module control
`timescale 1ns/1ps
module capture_scaler_and_jpeg_control
   import scaler_codec_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [7:0] chroma_in,
   input wire logic chroma_in_valid,
   output logic [7:0] chroma_out,
   output logic chroma_out_valid,
   output logic [5:0] h_rate,
   output logic [5:0] v_rate,
   output logic [1:0] scale_mode,
   output logic scaler_active,
   output logic scaler_rate_fault,
   output logic rotate_180,
   output logic codec_reset_pulse,
   output logic codec_enable,
   output logic codec_clock_enable,
   output logic [2:0] data_path,
   output logic path_reserved,
   output logic path_bypass,
   output logic path_encode_camera,
   output logic path_decode_to_display,
   output logic path_yuv_to_host,
   output logic path_host_in,
   output logic chroma_signed_camera,
   output logic chroma_signed_host
);
   // Decoded strobes between the APB front end and the register file
   cfg_bus_if bus ();

   // Stored register images and their next values
   logic [15:0] rates_reg;
   logic [15:0] rates_next;
   logic [15:0] mode_reg;
   logic [15:0] mode_next;
   logic [15:0] control_reg;
   logic [15:0] control_next;
   logic [15:0] scaler_ctrl_reg;
   logic [15:0] scaler_ctrl_next;
   logic [15:0] camera_fmt_reg;
   logic [15:0] camera_fmt_next;
   // One-shot codec reset and the chroma register stage
   logic reset_pulse_reg;
   logic reset_pulse_next;
   logic [7:0] chroma_reg;
   logic [7:0] chroma_next;
   logic chroma_valid_reg;
   logic chroma_valid_next;
   // Decoded scaler and path views of the registers
   logic [5:0] h_code;
   logic [5:0] v_code;
   logic h_ok;
   logic v_ok;
   logic offset_mode;
   scale_mode_t mode_sel;
   data_path_t path_sel;

   // --------------------------------------------------------------
   // Bus front end
   // --------------------------------------------------------------
   // Every access is answered in its first access cycle
   apb_front u_front (
      .pclk(pclk),
      .presetn(presetn),
      .psel(psel),
      .penable(penable),
      .pwrite(pwrite),
      .paddr(paddr),
      .pwdata(pwdata),
      .prdata(prdata),
      .pready(pready),
      .pslverr(pslverr),
      .bus(bus)
   );

   // --------------------------------------------------------------
   // Rate code checks
   // --------------------------------------------------------------
   // Codes 1..32 inclusive; zero and codes above 32 are reserved
   // Shared by both axes so the limits cannot drift apart
   function automatic logic rate_in_range(input logic [5:0] code);
      rate_in_range = (code >= RATE_MIN) && (code <= RATE_MAX);
   endfunction

   // Horizontal averaging only supports power-of-two divisors
   // A code with a single bit set is a power of two
   function automatic logic rate_pow2(input logic [5:0] code);
      rate_pow2 = rate_in_range(code) && ((code & (code - 6'h01)) == 6'h00);
   endfunction

   // --------------------------------------------------------------
   // Address decode and read mux
   // --------------------------------------------------------------
   // Unmapped offsets clear hit, so the front end raises an error
   // and the write strobe stays low
   always_comb begin
      bus.hit = 1'b1;
      bus.rdata = 16'h0000;
      unique case (bus.addr)
         ENCODE_SCALER_RATES_ADDR: bus.rdata = rates_reg;
         ENCODE_SCALER_MODE_ADDR: bus.rdata = mode_reg;
         // Reset trigger is never stored, so it reads as zero
         CODEC_MODULE_CONTROL_ADDR: bus.rdata = control_reg;
         ENCODE_SCALER_CONTROL_ADDR: bus.rdata = scaler_ctrl_reg;
         CAMERA_INPUT_FORMAT_ADDR: bus.rdata = camera_fmt_reg;
         default: bus.hit = 1'b0;
      endcase
   end

   // --------------------------------------------------------------
   // Register file next state
   // --------------------------------------------------------------
   // Masks keep unimplemented bits at zero, so they read back
   // as zero whatever software writes
   always_comb begin
      rates_next = rates_reg;
      mode_next = mode_reg;
      control_next = control_reg;
      scaler_ctrl_next = scaler_ctrl_reg;
      camera_fmt_next = camera_fmt_reg;
      reset_pulse_next = 1'b0;
      if (bus.wr_en) begin
         unique case (bus.addr)
            ENCODE_SCALER_RATES_ADDR: rates_next = bus.wdata & RATES_MASK;
            // Reserved bits 3-2 and upper bits stay zero
            ENCODE_SCALER_MODE_ADDR: mode_next = bus.wdata & MODE_MASK;
            // Bit 7 is a trigger only and is masked out of the image
            CODEC_MODULE_CONTROL_ADDR: begin
               control_next = bus.wdata & CONTROL_MASK;
               reset_pulse_next = bus.wdata[SOFT_RESET_BIT];
            end
            ENCODE_SCALER_CONTROL_ADDR: scaler_ctrl_next = bus.wdata & SCALER_CTRL_MASK;
            CAMERA_INPUT_FORMAT_ADDR: camera_fmt_next = bus.wdata & CAMERA_FMT_MASK;
            default: ;
         endcase
      end
   end

   // Register images; the reset pulse register lives here too
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rates_reg <= RATES_RESET;
         mode_reg <= MODE_RESET;
         control_reg <= CONTROL_RESET;
         scaler_ctrl_reg <= SCALER_CTRL_RESET;
         camera_fmt_reg <= CAMERA_FMT_RESET;
         reset_pulse_reg <= 1'b0;
      end else begin
         rates_reg <= rates_next;
         mode_reg <= mode_next;
         control_reg <= control_next;
         scaler_ctrl_reg <= scaler_ctrl_next;
         camera_fmt_reg <= camera_fmt_next;
         reset_pulse_reg <= reset_pulse_next;
      end
   end

   // --------------------------------------------------------------
   // Scaler rate and mode decode
   // --------------------------------------------------------------
   // Software is expected to load rates first; a bad combination
   // is caught here rather than trusted
   always_comb begin
      mode_sel = scale_mode_t'(mode_reg[MODE_LSB +: 2]);
      h_code = rates_reg[HRATE_LSB +: 6];
      // Shared rate when the axes are tied together
      v_code = scaler_ctrl_reg[INDEP_BIT] ? rates_reg[VRATE_LSB +: 6]
                                          : rates_reg[HRATE_LSB +: 6];
      // Vertical codes are range-checked the same way in every reduction mode
      v_ok = rate_in_range(v_code);
      // Horizontal validity depends on the selected mode
      h_ok = 1'b0;
      unique case (mode_sel)
         SCALE_NONE: h_ok = 1'b1;
         SCALE_REDUCE: h_ok = rate_in_range(h_code);
         SCALE_REDUCE_AVG: h_ok = rate_pow2(h_code);
         SCALE_RESERVED: h_ok = 1'b0;
      endcase
   end

   // Rate has no effect with no mode; fault only when a mode is live
   // Limitation: the fault only gates the enable; the image path
   // itself lies outside this block
   assign scaler_rate_fault = (mode_sel == SCALE_RESERVED) ||
      ((mode_sel != SCALE_NONE) && !(h_ok && v_ok));
   assign scaler_active = scaler_ctrl_reg[SCALER_EN_BIT] && !scaler_rate_fault;
   // Mode as stored; effective rates read as unity with no scaling
   assign scale_mode = mode_reg[MODE_LSB +: 2];
   assign h_rate = (mode_sel == SCALE_NONE) ? RATE_MIN : h_code;
   assign v_rate = (mode_sel == SCALE_NONE) ? RATE_MIN : v_code;

   // --------------------------------------------------------------
   // Codec control decode
   // --------------------------------------------------------------
   // Rotation only means something for camera-sourced encoding
   assign rotate_180 = control_reg[ROTATE_BIT] && path_encode_camera;
   assign codec_reset_pulse = reset_pulse_reg;
   // Enable and clock gate share one bit; software turns the
   // module off before it drops a scaler enable
   assign codec_enable = control_reg[ENABLE_BIT];
   assign codec_clock_enable = control_reg[ENABLE_BIT];
   assign data_path = control_reg[PATH_LSB +: 3];

   // Path decode; reserved codes only raise path_reserved
   always_comb begin
      path_sel = data_path_t'(control_reg[PATH_LSB +: 3]);
      path_reserved = 1'b0;
      path_bypass = 1'b0;
      path_encode_camera = 1'b0;
      path_decode_to_display = 1'b0;
      path_yuv_to_host = 1'b0;
      path_host_in = 1'b0;
      offset_mode = 1'b0;
      unique case (path_sel)
         PATH_CODEC: begin
            path_encode_camera = 1'b1;
            path_decode_to_display = 1'b1;
         end
         PATH_YUV422_IN, PATH_YUV420_IN: begin
            path_bypass = 1'b1;
            path_host_in = 1'b1;
            offset_mode = 1'b1;
         end
         PATH_YUV422_OUT, PATH_YUV420_OUT: begin
            path_bypass = 1'b1;
            path_yuv_to_host = 1'b1;
            offset_mode = 1'b1;
         end
         PATH_HOST_CODEC: begin
            path_host_in = 1'b1;
            path_yuv_to_host = 1'b1;
            offset_mode = 1'b1;
         end
         PATH_RSVD2, PATH_RSVD6: path_reserved = 1'b1;
      endcase
   end

   // Signedness of chroma seen at each side of the path
   // Offset-format input data flips the sense
   assign chroma_signed_camera = (camera_fmt_reg[CAM_STRAIGHT_BIT] ==
      control_reg[NO_OFFSET_BIT]) ^ camera_fmt_reg[CAM_OFFSET_IN_BIT];
   assign chroma_signed_host = ~control_reg[NO_OFFSET_BIT] ^
      camera_fmt_reg[CAM_OFFSET_IN_BIT];

   // --------------------------------------------------------------
   // Chroma offset stage
   // --------------------------------------------------------------
   // One register stage; the MSB flip is the whole offset conversion
   always_comb begin
      chroma_next = chroma_in;
      chroma_valid_next = chroma_in_valid;
      if (offset_mode && !control_reg[NO_OFFSET_BIT]) begin
         chroma_next = {~chroma_in[7], chroma_in[6:0]};
      end
   end

   // Valid travels with its sample so both leave together
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         chroma_reg <= 8'h00;
         chroma_valid_reg <= 1'b0;
      end else begin
         chroma_reg <= chroma_next;
         chroma_valid_reg <= chroma_valid_next;
      end
   end

   // Both outputs come straight from flip-flops
   assign chroma_out = chroma_reg;
   assign chroma_out_valid = chroma_valid_reg;
endmodule

// ===== verification/capture_scaler_and_jpeg_control_assertions.sv
// Checker: port-level properties of the scaler and codec control block
`timescale 1ns/1ps
module capture_scaler_and_jpeg_control_assertions (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [7:0] chroma_in,
   input wire logic chroma_in_valid,
   input wire logic [7:0] chroma_out,
   input wire logic chroma_out_valid,
   input wire logic [5:0] h_rate,
   input wire logic [5:0] v_rate,
   input wire logic [1:0] scale_mode,
   input wire logic scaler_active,
   input wire logic scaler_rate_fault,
   input wire logic rotate_180,
   input wire logic codec_reset_pulse,
   input wire logic codec_enable,
   input wire logic codec_clock_enable,
   input wire logic [2:0] data_path,
   input wire logic path_reserved,
   input wire logic path_bypass
);
   // ------------------------------------------------
   // Properties, all in the one clock domain
   // ------------------------------------------------
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   ready_now_a: assert property ((psel && penable) == pready)
      else $error("ready not tied to access phase");
   err_phase_a: assert property (pslverr |-> psel && penable)
      else $error("error outside access phase");
   pulse_single_a: assert property (codec_reset_pulse |=> !codec_reset_pulse)
      else $error("reset pulse longer than one cycle");
   clock_follow_a: assert property (codec_clock_enable == codec_enable)
      else $error("clock enable differs from module enable");
   rotate_path_a: assert property (rotate_180 |-> data_path == 3'h0)
      else $error("rotation outside path 000");
   path_rsvd_a: assert property (path_reserved == (data_path inside {3'h2, 3'h6}))
      else $error("reserved path decode wrong");
   bypass_code_a: assert property (path_bypass == data_path[0])
      else $error("bypass decode wrong");
   chroma_plain_a: assert property (chroma_in_valid && data_path inside {3'h0, 3'h2, 3'h6}
      |=> chroma_out_valid && chroma_out == $past(chroma_in))
      else $error("chroma altered outside offset paths");
   chroma_low_a: assert property (chroma_in_valid |=> chroma_out[6:0] == $past(chroma_in[6:0]))
      else $error("chroma low bits altered");
   idle_rate_a: assert property (scale_mode == 2'h0 |-> h_rate == 6'h01 && v_rate == 6'h01)
      else $error("rates not unity without scaling");
   rsvd_mode_a: assert property (scale_mode == 2'h3 |-> scaler_rate_fault)
      else $error("reserved mode not flagged");
   fault_off_a: assert property (scaler_rate_fault |-> !scaler_active)
      else $error("scaler active with bad rate");
   avg_pow2_a: assert property (scale_mode == 2'h2 && !scaler_rate_fault |-> $onehot(h_rate))
      else $error("averaging ratio not a power of two");
   // Main scenarios reached
   cover property (codec_reset_pulse);
   cover property (scaler_rate_fault && scale_mode != 2'h3);
   cover property (rotate_180);
endmodule

// ===== verification/host_model.sv
// Host model: APB master that programs the configuration registers
`timescale 1ns/1ps
module host_model (
   input wire logic pclk,
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [31:0] paddr,
   output logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr
);
   int timeouts = 0;
   // Bus idle from time zero
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 32'h0;
      pwdata = 32'h0;
   end
   // Read data and response are both taken at the edge that sees pready high
   task automatic xfer(input logic wr, input logic [13:0] a, input logic [15:0] d,
         output logic [15:0] q, output logic err);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= {18'h0, a};
      pwdata <= {16'h0, d};
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      if (pready !== 1'b1) timeouts++;
      err = pslverr;
      q = prdata[15:0];
      psel <= 1'b0;
      penable <= 1'b0;
      // Turned over when idle so stale values never pass for valid ones
      paddr <= ~paddr;
      pwdata <= ~pwdata;
      // One more edge so register updates settle before the caller looks
      @(posedge pclk);
   endtask
endmodule

// ===== verification/capture_scaler_and_jpeg_control_tb.sv
// Testbench: register access, scaling decode, path decode and chroma handling
`timescale 1ns/1ps
module capture_scaler_and_jpeg_control_tb;
   import scaler_codec_pkg::*;
   logic pclk, presetn, psel, penable, pwrite, chroma_in_valid, pready, pslverr;
   logic [31:0] paddr, pwdata, prdata;
   logic chroma_out_valid, scaler_active, scaler_rate_fault, rotate_180, codec_reset_pulse;
   logic codec_enable, codec_clock_enable, path_reserved, path_bypass, path_encode_camera;
   logic path_decode_to_display, path_yuv_to_host, path_host_in;
   logic chroma_signed_camera, chroma_signed_host;
   logic [7:0] chroma_in, chroma_out;
   logic [5:0] h_rate, v_rate;
   logic [1:0] scale_mode;
   logic [2:0] data_path;
   int failures = 0;
   int checks = 0;
   int pulses = 0;
   capture_scaler_and_jpeg_control capture_scaler_and_jpeg_control_inst (.pclk(pclk),
      .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .chroma_in(chroma_in), .chroma_in_valid(chroma_in_valid), .chroma_out(chroma_out),
      .chroma_out_valid(chroma_out_valid), .h_rate(h_rate), .v_rate(v_rate),
      .scale_mode(scale_mode), .scaler_active(scaler_active),
      .scaler_rate_fault(scaler_rate_fault), .rotate_180(rotate_180),
      .codec_reset_pulse(codec_reset_pulse), .codec_enable(codec_enable),
      .codec_clock_enable(codec_clock_enable), .data_path(data_path),
      .path_reserved(path_reserved), .path_bypass(path_bypass),
      .path_encode_camera(path_encode_camera), .path_decode_to_display(path_decode_to_display),
      .path_yuv_to_host(path_yuv_to_host), .path_host_in(path_host_in),
      .chroma_signed_camera(chroma_signed_camera), .chroma_signed_host(chroma_signed_host));
   host_model host_model_inst (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
   // Clock and watchdog; the watchdog keeps a hung handshake from stalling the run
   initial begin
      pclk = 1'b0;
      forever #25 pclk = ~pclk;
   end
   initial begin
      repeat (100000) @(posedge pclk);
      failures++;
      finish_test();
   end
   always @(posedge pclk) if (codec_reset_pulse === 1'b1) pulses++;
   task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
      checks++;
      if (got !== exp) begin
         failures++;
         $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   task automatic wr(input logic [13:0] a, input logic [15:0] d);
      logic [15:0] q;
      logic e;
      host_model_inst.xfer(1'b1, a, d, q, e);
   endtask
   function automatic logic bad(input logic [1:0] m, input logic [5:0] h, input logic [5:0] v);
      logic bh;
      bh = h == 6'h00 || h > 6'h20 || (m == 2'h2 && !(h inside {1, 2, 4, 8, 16, 32}));
      return m == 2'h3 || (m != 2'h0 && (bh || v == 6'h00 || v > 6'h20));
   endfunction
   task automatic finish_test();
      failures += host_model_inst.timeouts;
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   // Main sequence
   initial begin
      logic [15:0] q, x;
      logic e;
      logic [5:0] h, v;
      int n0;
      presetn = 1'b0;
      chroma_in = 8'h00;
      chroma_in_valid = 1'b0;
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      // Reset values, masks and an unmapped place
      host_model_inst.xfer(1'b0, ENCODE_SCALER_RATES_ADDR, 16'h0, q, e);
      check(q, 16'h0101, "rates reset");
      host_model_inst.xfer(1'b0, ENCODE_SCALER_MODE_ADDR, 16'h0, q, e);
      check(q, 16'h0000, "mode reset");
      host_model_inst.xfer(1'b0, 14'h0004, 16'h0, q, e);
      check({q[14:0], e}, 16'h0001, "unmapped");
      wr(ENCODE_SCALER_MODE_ADDR, 16'hFFFF);
      host_model_inst.xfer(1'b0, ENCODE_SCALER_MODE_ADDR, 16'h0, q, e);
      check(q, 16'h0003, "mode reserved bits");
      // Every mode against rate codes 0 to 34 on each axis
      wr(ENCODE_SCALER_CONTROL_ADDR, 16'h0005);
      for (int m = 0; m < 4; m++) begin
         for (int c = 0; c < 35; c++) begin
            for (int ax = 0; ax < 2; ax++) begin
               h = ax ? 6'h01 : 6'(c);
               v = ax ? 6'(c) : 6'h01;
               wr(ENCODE_SCALER_MODE_ADDR, 16'h0000);
               wr(ENCODE_SCALER_RATES_ADDR, {2'b00, v, 2'b00, h});
               wr(ENCODE_SCALER_MODE_ADDR, {14'h0, 2'(m)});
               x = {14'h0, bad(2'(m), h, v), !bad(2'(m), h, v)};
               check({14'h0, scaler_rate_fault, scaler_active}, x, "fault");
               check({14'h0, scale_mode}, 16'(m), "mode");
               x = (m == 0) ? 16'h0041 : {4'h0, h, v};
               if (!bad(2'(m), h, v)) check({4'h0, h_rate, v_rate}, x, "rates");
            end
         end
      end
      // Shared rate when the axes are not independent
      wr(ENCODE_SCALER_CONTROL_ADDR, 16'h0001);
      wr(ENCODE_SCALER_RATES_ADDR, 16'h0504);
      check({4'h0, h_rate, v_rate}, 16'h0104, "shared rate");
      // Module reset trigger and enable
      n0 = pulses;
      wr(CODEC_MODULE_CONTROL_ADDR, 16'h0001);
      wr(CODEC_MODULE_CONTROL_ADDR, 16'h0081);
      repeat (2) @(posedge pclk);
      check(16'(pulses - n0), 16'h0001, "reset pulses");
      host_model_inst.xfer(1'b0, CODEC_MODULE_CONTROL_ADDR, 16'h0, q, e);
      check(q, 16'h0001, "trigger reads zero");
      check({14'h0, codec_enable, codec_clock_enable}, 16'h0003, "enable");
      // Every path code, offset on and off, with one chroma sample each
      for (int b = 0; b < 2; b++) begin
         for (int k = 0; k < 8; k++) begin
            wr(CODEC_MODULE_CONTROL_ADDR, {7'h0, 1'b1, 3'h0, 1'(b), 3'(k), 1'b1});
            x = {6'h0, 3'(k), k == 0, k == 2 || k == 6, k[0] == 1, k == 0, k == 0,
               k == 3 || k == 4 || k == 7, k == 1 || k == 4 || k == 5};
            check({6'h0, data_path, rotate_180, path_reserved, path_bypass,
               path_encode_camera, path_decode_to_display, path_yuv_to_host,
               path_host_in}, x, "path");
            chroma_in <= 8'hA5 ^ 8'(k);
            chroma_in_valid <= 1'b1;
            @(posedge pclk);
            chroma_in_valid <= 1'b0;
            @(negedge pclk);
            x = {7'h0, 1'b1, 8'hA5 ^ 8'(k) ^ {k inside {1, 3, 4, 5, 7} && b == 0, 7'h0}};
            check({7'h0, chroma_out_valid, chroma_out}, x, "chroma");
         end
      end
      // Signed or unsigned chroma against camera format and offset select
      for (int i = 0; i < 8; i++) begin
         wr(CAMERA_INPUT_FORMAT_ADDR, {6'h0, 2'(i >> 1), 8'h0});
         wr(CODEC_MODULE_CONTROL_ADDR, {11'h0, 1'(i), 3'h3, 1'b1});
         x = {15'h0, (i[1] == i[0]) ^ i[2]};
         check({15'h0, chroma_signed_camera}, x, "camera sign");
         if (i < 4) check({15'h0, chroma_signed_host}, {15'h0, !i[0]}, "host sign");
      end
      // Module off before the scaler enable is cleared
      wr(CODEC_MODULE_CONTROL_ADDR, 16'h0000);
      wr(ENCODE_SCALER_CONTROL_ADDR, 16'h0000);
      check({14'h0, codec_enable, scaler_active}, 16'h0000, "all off");
      finish_test();
   end
endmodule
bind capture_scaler_and_jpeg_control capture_scaler_and_jpeg_control_assertions chk_inst (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pready(pready),
   .pslverr(pslverr), .chroma_in(chroma_in), .chroma_in_valid(chroma_in_valid),
   .chroma_out(chroma_out), .chroma_out_valid(chroma_out_valid), .h_rate(h_rate),
   .v_rate(v_rate), .scale_mode(scale_mode), .scaler_active(scaler_active),
   .scaler_rate_fault(scaler_rate_fault), .rotate_180(rotate_180),
   .codec_reset_pulse(codec_reset_pulse), .codec_enable(codec_enable),
   .codec_clock_enable(codec_clock_enable), .data_path(data_path),
   .path_reserved(path_reserved), .path_bypass(path_bypass));
